// ---- core/timer1_pkg.sv ----
// Constants shared by the 10-bit timer, PWM and buzzer block.
package timer1_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned PS_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_COUNT_LOW = 3'h0;
  localparam logic [2:0] IDX_CTRL_ONE = 3'h1;
  localparam logic [2:0] IDX_CTRL_TWO = 3'h2;
  localparam logic [2:0] IDX_DUTY_LOW = 3'h3;
  localparam logic [2:0] IDX_PRESC_VAL = 3'h4;
  localparam logic [2:0] IDX_BUZZER = 3'h5;
  localparam logic [2:0] IDX_SHARED_HIGH = 3'h6;
  localparam logic [2:0] IDX_MISC = 3'h7;
  // Field positions of timer_control_one
  localparam int unsigned C1_ENABLE = 0;
  localparam int unsigned C1_RELOAD = 1;
  localparam int unsigned C1_ONE_SHOT = 2;
  localparam int unsigned C1_UF_OE = 5;
  localparam int unsigned C1_POLARITY = 6;
  localparam int unsigned C1_PWM_OE = 7;
  // Field positions of timer_control_two
  localparam int unsigned C2_SEL_LSB = 0;
  localparam int unsigned C2_SEL_MSB = 2;
  localparam int unsigned C2_PS_DIS_N = 3;
  localparam int unsigned C2_EDGE = 4;
  localparam int unsigned C2_SOURCE = 5;
  // Field positions of buzzer_control, shared_high_bits and misc
  localparam int unsigned BZ_ENABLE = 7;
  localparam int unsigned BZ_SEL_MSB = 3;
  localparam int unsigned HI_RELOAD_LSB = 4;
  localparam int unsigned HI_RELOAD_MSB = 5;
  localparam int unsigned HI_DUTY_LSB = 0;
  localparam int unsigned HI_DUTY_MSB = 1;
  localparam int unsigned MISC_FORCE = 0;
  localparam int unsigned MISC_FLAG = 1;
  // Reset values and read masks
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [5:0] CTRL_TWO_RST = 6'h3f;
  localparam logic [7:0] BUZZER_RST = 8'h0f;
  localparam logic [7:0] PRESC_RST = 8'hff;
  localparam logic [7:0] HIGH_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] CTRL_ONE_MASK = 8'he7;
  localparam logic [7:0] BUZZER_MASK = 8'h8f;
  localparam logic [9:0] COUNT_RST = 10'h000;
  localparam logic [9:0] COUNT_MAX = 10'h3ff;
  localparam logic [9:0] COUNT_ONE = 10'h001;
  localparam logic [8:0] PS_UNIT = 9'h001;
endpackage : timer1_pkg

// ---- core/timer1_pwm_buzzer.sv ----
// Timer with prescaler, PWM, underflow toggle and buzzer behind an Avalon-MM slave.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RL1] Count register read returns live count
// [RL2] Count write loads high bits plus byte
// [RL3] Free-run without reload restarts at 0x3ff
// [RL4] Free-run with reload restarts at reload
// [RL5] One-shot counts to zero then halts
// [RL6] Polarity bit set makes PWM active low
// [RL7] PWM enable drives PB3 and PB4
// [RL8] Underflow toggle drives PB4 when enabled
// [RL9] Prescaler select divides 1:2 to 1:256
// [RL10] Software changes select only while bypassed
// [RL11] Bypass prescaler when high oscillator clocks; the code bypasses only on C2_PS_DIS_N, and the force does not bypass
// [RL12] Edge bit picks falling or rising edge
// [RL13] Source bit picks pin or internal clock
// [RL14] PWM period reload, duty high plus byte
// [RL15] Prescaler value register reads live count
// [RL16] Buzzer codes 0-7 give prescaler divisions
// [RL17] Buzzer codes 8-15 route timer bits
// [RL18] High oscillator force overrides source bit
// [RL19] Counter only moves while timer enabled
// [RL20] Each underflow raises a sticky flag
module timer1_pwm_buzzer
  import timer1_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [DATA_W-1:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  // Clock sources: ticks from the system clock domain, plus the raw external pin
  input wire logic instr_tick_i,
  input wire logic hosc_tick_i,
  input wire logic external_clock_pin_i,
  // Pins
  output logic pb3_out_o,
  output logic pb3_drive_n_o,
  output logic pb4_out_o,
  output logic pb4_drive_n_o,
  output logic buzzer_output_o,
  // Event
  output logic underflow_pulse_o
);

  // Bus handshake state
  logic ack_r; // High in the accept cycle
  logic req; // Any request present
  logic mapped; // Address falls inside the map
  logic [2:0] idx; // Register index
  logic wr_acc; // Write takes effect this edge
  logic rd_load; // Read data captured this edge
  logic [7:0] rd_byte; // Selected read byte
  logic [DATA_W-1:0] readdata_r;

  // Register file
  logic [CNT_W-1:0] count_r, count_nxt;
  logic [7:0] reload_low_r;
  logic [7:0] ctrl_one_r;
  logic [5:0] ctrl_two_r;
  logic [7:0] duty_low_r;
  logic [7:0] buzzer_r;
  logic [7:0] high_r;
  logic force_r; // Shared high-oscillator force
  logic flag_r, flag_nxt; // Sticky underflow event

  // Write strobes per register
  logic wr_count, wr_ctrl_one, wr_ctrl_two, wr_duty, wr_buzzer, wr_high, wr_misc;

  // Clock source path
  logic ext_meta_r, ext_sync_r, ext_prev_r;
  logic ext_rise, ext_fall, ext_tick, int_tick, use_ext, src_tick;

  // Prescaler
  logic [PS_W-1:0] ps_cnt_r;
  logic [8:0] ps_span;
  logic [PS_W-1:0] ps_mask;
  logic ps_bypass, ps_tick, timer_tick;

  // Timer core
  logic [CNT_W-1:0] reload_val, duty_val, load_val;
  logic step, underflow, cnt_zero, halted_r, halted_nxt;
  logic toggle_r;

  // Outputs
  logic pwm_raw, pwm_level;
  logic pb3_r, pb4_r, buzz_r, buzz_tap, uf_pulse_r;

  // Decode of the Avalon request; upper address bit means unmapped
  assign req = read_i | write_i;
  assign mapped = ~address_i[ADDR_W-1];
  assign idx = address_i[4:2];
  assign waitrequest_o = req & ~ack_r;
  assign rd_load = read_i & ~ack_r;
  assign wr_acc = write_i & ack_r & byteenable_i[0] & mapped;
  assign wr_count = wr_acc & (idx == IDX_COUNT_LOW);
  assign wr_ctrl_one = wr_acc & (idx == IDX_CTRL_ONE);
  assign wr_ctrl_two = wr_acc & (idx == IDX_CTRL_TWO);
  assign wr_duty = wr_acc & (idx == IDX_DUTY_LOW);
  assign wr_buzzer = wr_acc & (idx == IDX_BUZZER);
  assign wr_high = wr_acc & (idx == IDX_SHARED_HIGH);
  assign wr_misc = wr_acc & (idx == IDX_MISC);

  // One wait state on every access: data is ready at the accept edge
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read mux; duty register is write-only and reads zero
  always_comb begin
    rd_byte = BYTE_ZERO;
    if (mapped) begin
      unique case (idx)
        // [RL1] live count low byte
        IDX_COUNT_LOW: rd_byte = count_r[7:0];
        IDX_CTRL_ONE: rd_byte = ctrl_one_r & CTRL_ONE_MASK;
        IDX_CTRL_TWO: rd_byte = {2'h0, ctrl_two_r};
        IDX_DUTY_LOW: rd_byte = BYTE_ZERO;
        // [RL15] prescaler count readback
        IDX_PRESC_VAL: rd_byte = ps_cnt_r;
        IDX_BUZZER: rd_byte = buzzer_r & BUZZER_MASK;
        IDX_SHARED_HIGH: rd_byte = high_r;
        IDX_MISC: rd_byte = {6'h00, flag_r, force_r};
      endcase
    end
  end

  // Read data captured in the wait cycle and held until the next read
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      readdata_r <= '0;
    end else if (rd_load) begin
      readdata_r <= {24'h000000, rd_byte};
    end
  end
  assign readdata_o = readdata_r;

  // Configuration registers
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl_one_r <= CTRL_ONE_RST;
      ctrl_two_r <= CTRL_TWO_RST;
      duty_low_r <= BYTE_ZERO;
      buzzer_r <= BUZZER_RST;
      high_r <= HIGH_RST;
      force_r <= 1'b0;
      reload_low_r <= BYTE_ZERO;
    end else begin
      if (wr_ctrl_one) ctrl_one_r <= writedata_i[7:0];
      if (wr_ctrl_two) ctrl_two_r <= writedata_i[5:0];
      if (wr_duty) duty_low_r <= writedata_i[7:0];
      if (wr_buzzer) buzzer_r <= writedata_i[7:0];
      if (wr_high) high_r <= writedata_i[7:0];
      if (wr_misc) force_r <= writedata_i[MISC_FORCE];
      if (wr_count) reload_low_r <= writedata_i[7:0];
    end
  end

  // External pin synchroniser; only the second and third stages are examined
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= external_clock_pin_i;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // [RL12] edge polarity of the pin
  assign ext_rise = ext_sync_r & ~ext_prev_r;
  assign ext_fall = ~ext_sync_r & ext_prev_r;
  assign ext_tick = ctrl_two_r[C2_EDGE] ? ext_fall : ext_rise;
  // [RL18] force overrides source bit
  assign int_tick = force_r ? hosc_tick_i : instr_tick_i;
  // [RL13] pin or internal source
  assign use_ext = ctrl_two_r[C2_SOURCE] & ~force_r;
  assign src_tick = use_ext ? ext_tick : int_tick;

  // [RL9] tap mask sets division 2^(sel+1)
  // Shift is widened by one bit so that select 7 reaches 2^8 instead of wrapping to 2^0
  assign ps_span = PS_UNIT << ({1'b0, ctrl_two_r[C2_SEL_MSB:C2_SEL_LSB]} + 4'h1);
  assign ps_mask = PS_W'(ps_span - PS_UNIT);
  assign ps_bypass = ctrl_two_r[C2_PS_DIS_N];
  assign ps_tick = src_tick & ~ps_bypass & ((ps_cnt_r & ps_mask) == BYTE_ZERO);
  assign timer_tick = ps_bypass ? src_tick : ps_tick;

  // Prescaler counts down on source ticks; it freezes while bypassed
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ps_cnt_r <= PRESC_RST;
    end else if (src_tick & ~ps_bypass) begin
      ps_cnt_r <= ps_cnt_r - 8'h01;
    end
  end

  // Reload and duty values assembled from the shared high register
  assign reload_val = {high_r[HI_RELOAD_MSB:HI_RELOAD_LSB], reload_low_r};
  assign duty_val = {high_r[HI_DUTY_MSB:HI_DUTY_LSB], duty_low_r};
  assign load_val = {high_r[HI_RELOAD_MSB:HI_RELOAD_LSB], writedata_i[7:0]};
  assign cnt_zero = (count_r == COUNT_RST);
  // [RL19] movement gated by enable bit
  assign step = timer_tick & ctrl_one_r[C1_ENABLE] & ~halted_r;
  assign underflow = step & cnt_zero;

  // Next count; a bus load beats a simultaneous tick
  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      // [RL2] load from high bits and byte
      count_nxt = load_val;
    end else if (underflow) begin
      if (ctrl_one_r[C1_ONE_SHOT]) begin
        // [RL5] one-shot stays at zero
        count_nxt = COUNT_RST;
      end else if (ctrl_one_r[C1_RELOAD]) begin
        // [RL4] restart from reload value
        count_nxt = reload_val;
      end else begin
        // [RL3] restart from full count
        count_nxt = COUNT_MAX;
      end
    end else if (step) begin
      count_nxt = count_r - COUNT_ONE;
    end
  end

  // Halt latch of one-shot mode; a new load or leaving one-shot rearms
  assign halted_nxt = (wr_count | ~ctrl_one_r[C1_ONE_SHOT]) ? 1'b0 : (halted_r | underflow);

  // [RL20] set wins over software clear
  assign flag_nxt = underflow | (flag_r & ~(wr_misc & writedata_i[MISC_FLAG]));

  // Counter, halt, toggle and flag state
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      count_r <= COUNT_RST;
      halted_r <= 1'b0;
      toggle_r <= 1'b0;
      flag_r <= 1'b0;
      uf_pulse_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      halted_r <= halted_nxt;
      // [RL8] invert on each underflow
      toggle_r <= toggle_r ^ underflow;
      flag_r <= flag_nxt;
      uf_pulse_r <= underflow;
    end
  end

  // [RL14] active while count is below duty within the reload frame
  assign pwm_raw = (count_r < duty_val);
  // [RL6] polarity inversion
  assign pwm_level = pwm_raw ^ ctrl_one_r[C1_POLARITY];

  // [RL16] prescaler tap, [RL17] timer bit tap
  assign buzz_tap = buzzer_r[BZ_SEL_MSB] ? count_r[buzzer_r[2:0]] : ps_cnt_r[buzzer_r[2:0]];

  // Pin and buzzer data registers; PWM takes PB4 ahead of the toggle
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pb3_r <= 1'b0;
      pb4_r <= 1'b0;
      buzz_r <= 1'b0;
    end else begin
      pb3_r <= pwm_level;
      // [RL7] PWM owns PB4 when enabled
      pb4_r <= ctrl_one_r[C1_PWM_OE] ? pwm_level : toggle_r;
      // [RL16] silent while disabled
      buzz_r <= buzzer_r[BZ_ENABLE] & buzz_tap;
    end
  end

  // [RL7] pin ownership, enables low while driving
  assign pb3_drive_n_o = ~ctrl_one_r[C1_PWM_OE];
  // [RL8] PB4 taken by toggle or PWM
  assign pb4_drive_n_o = ~(ctrl_one_r[C1_PWM_OE] | ctrl_one_r[C1_UF_OE]);
  assign pb3_out_o = pb3_r;
  assign pb4_out_o = pb4_r;
  assign buzzer_output_o = buzz_r;
  assign underflow_pulse_o = uf_pulse_r;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_uf_free;
    underflow && !wr_count && !ctrl_one_r[C1_ONE_SHOT];
  endsequence
  sequence s_read_count;
    read_i && ack_r && mapped && (idx == IDX_COUNT_LOW);
  endsequence

  a_count_read: assert property (s_read_count |-> readdata_o[7:0] == $past(count_r[7:0])) // [RL1]
    else $error("count read mismatch");
  a_count_load: assert property (wr_count |=> count_r == {$past(high_r[HI_RELOAD_MSB:HI_RELOAD_LSB]), $past(writedata_i[7:0])}) // [RL2]
    else $error("count load mismatch");
  a_free_max: assert property (s_uf_free and !ctrl_one_r[C1_RELOAD] |=> count_r == COUNT_MAX) // [RL3]
    else $error("free run restart wrong");
  a_free_reload: assert property (s_uf_free and ctrl_one_r[C1_RELOAD] |=> count_r == $past(reload_val)) // [RL4]
    else $error("reload restart wrong");
  a_one_shot_halt: assert property (underflow && ctrl_one_r[C1_ONE_SHOT] && !wr_count // [RL5]
      |=> (cnt_zero && halted_r) [*2] or (wr_count || !ctrl_one_r[C1_ONE_SHOT]))
    else $error("one-shot did not halt");
  a_pwm_level: assert property (##1 pb3_out_o == (($past(count_r) < $past(duty_val)) ^ $past(ctrl_one_r[C1_POLARITY]))) // [RL6]
    else $error("pwm level wrong");
  a_toggle_flip: assert property (underflow |=> toggle_r != $past(toggle_r) && flag_r && underflow_pulse_o) // [RL8]
    else $error("underflow effects missing");
  // Tap is checked by shifting out all but the low sel+1 bits, independent of the mask logic
  a_presc_tap: assert property (ps_tick |-> src_tick && !ps_bypass // [RL9]
      && (PS_W'(ps_cnt_r << ~ctrl_two_r[C2_SEL_MSB:C2_SEL_LSB]) == BYTE_ZERO))
    else $error("prescaler tick off tap");
  // Both PWM pins carry the same level while PWM owns them
  a_pwm_both_pins: assert property (ctrl_one_r[C1_PWM_OE] |=> pb4_out_o == pb3_out_o) // [RL7]
    else $error("pwm pins differ");
  a_hold_disabled: assert property (!ctrl_one_r[C1_ENABLE] && !wr_count |=> count_r == $past(count_r)) // [RL19]
    else $error("counter moved while disabled");
  a_buzz_silent: assert property (!buzzer_r[BZ_ENABLE] |=> !buzzer_output_o) // [RL16]
    else $error("buzzer not silent");

endmodule // timer1_pwm_buzzer

`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the timer, PWM and buzzer block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import timer1_pkg::*;
  // Bus side, tick sources and pins
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] address_i = '0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [DATA_W-1:0] writedata_i = '0;
  logic [3:0] byteenable_i = 4'h1;
  logic [DATA_W-1:0] readdata_o;
  logic waitrequest_o;
  logic instr_tick_i = 1'b0;
  logic hosc_tick_i = 1'b0;
  logic external_clock_pin_i = 1'b0;
  logic pb3_out_o, pb3_drive_n_o, pb4_out_o, pb4_drive_n_o, buzzer_output_o, underflow_pulse_o;
  // Bookkeeping; psc mirrors the prescaler count
  int num_errors = 0;
  int comparisons = 0;
  int pulses = 0;
  int p0;
  logic [31:0] rng = 32'h00012c67;
  logic [7:0] exp_q[$];
  logic [7:0] psc = 8'hff;
  logic last;

  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;

  timer1_pwm_buzzer u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .instr_tick_i(instr_tick_i),
    .hosc_tick_i(hosc_tick_i), .external_clock_pin_i(external_clock_pin_i), .pb3_out_o(pb3_out_o),
    .pb3_drive_n_o(pb3_drive_n_o), .pb4_out_o(pb4_out_o), .pb4_drive_n_o(pb4_drive_n_o),
    .buzzer_output_o(buzzer_output_o), .underflow_pulse_o(underflow_pulse_o));

  // Seeded xorshift for count loads
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Word comparison, used for read data; upper lanes must read zero
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pin comparison
  task automatic check_pin(input logic got, input logic exp);
    check({31'h00000000, got}, {31'h00000000, exp});
  endtask

  // One Avalon transfer; request held until waitrequest is seen low, a hang is left to the watchdog
  task automatic bus(input logic is_wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    address_i <= a;
    read_i <= ~is_wr;
    write_i <= is_wr;
    writedata_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys_i);
    end while (waitrequest_o !== 1'b0);
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // Expectation is queued before the request goes out
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  // One-cycle ticks on the instruction or high oscillator input
  task automatic tick(input int n, input bit hosc);
    repeat (n) begin
      @(posedge clk_sys_i);
      if (hosc) hosc_tick_i <= 1'b1;
      else instr_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      hosc_tick_i <= 1'b0;
      instr_tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_sys_i);
  endtask

  // One rise and one fall, each held past the synchroniser delay
  task automatic pin_pulse();
    @(posedge clk_sys_i);
    external_clock_pin_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    external_clock_pin_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Read data monitor; also counts underflow events
  always @(posedge clk_sys_i) begin
    if (read_i && waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("wrong value at %0t: got %h with no expectation queued", $time, readdata_o);
      end else begin
        check(readdata_o, {24'h000000, exp_q.pop_front()});
      end
    end
    if (underflow_pulse_o === 1'b1) pulses++;
  end

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    num_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // Reset values, write-only, read-only and unmapped places
    rd(6'h04, 8'h00);
    rd(6'h08, 8'h3f);
    rd(6'h10, 8'hff);
    rd(6'h14, 8'h0f);
    rd(6'h0c, 8'h00);
    wr(6'h10, 8'h12);
    rd(6'h10, 8'hff);
    wr(6'h20, 8'h55);
    rd(6'h20, 8'h00);
    $display("test reset done");
    // Count loads read back with the timer stopped
    wr(6'h18, 8'h30);
    repeat (4) begin
      rng = xorshift(rng);
      wr(6'h00, rng[7:0]);
      rd(6'h00, rng[7:0]);
    end
    $display("test load done");
    // PWM level, polarity and pin ownership; count 0x010 below duty 0x020
    wr(6'h18, 8'h00);
    wr(6'h00, 8'h10);
    wr(6'h0c, 8'h20);
    wr(6'h04, 8'h80);
    settle();
    check_pin(pb3_out_o, 1'b1);
    check_pin(pb3_drive_n_o, 1'b0);
    check_pin(pb4_drive_n_o, 1'b0);
    wr(6'h04, 8'hc0);
    settle();
    check_pin(pb3_out_o, 1'b0);
    wr(6'h04, 8'h00);
    settle();
    check_pin(pb3_drive_n_o, 1'b1);
    check_pin(pb4_drive_n_o, 1'b1);
    $display("test pwm done");
    // Buzzer routes each of count bits 0 to 7, then silence
    for (int k = 0; k < 8; k++) begin
      wr(6'h00, 8'h01 << k);
      wr(6'h14, 8'h88 + 8'(k));
      settle();
      check_pin(buzzer_output_o, 1'b1);
    end
    wr(6'h14, 8'h08);
    settle();
    check_pin(buzzer_output_o, 1'b0);
    $display("test buzzer bits done");
    // Free run from 1: underflow wraps to 0x3ff, toggles PB4, flags the event
    wr(6'h08, 8'h08);
    wr(6'h00, 8'h01);
    last = pb4_out_o;
    p0 = pulses;
    wr(6'h04, 8'h21);
    // The control write lands at the accept edge, so let it settle before looking at the pins
    settle();
    check_pin(pb4_drive_n_o, 1'b0);
    check_pin(pb3_drive_n_o, 1'b1);
    tick(2, 1'b0);
    rd(6'h00, 8'hff);
    check_pin(pb4_out_o, ~last);
    check(32'(pulses - p0), 32'h00000001);
    rd(6'h1c, 8'h02);
    wr(6'h1c, 8'h02);
    rd(6'h1c, 8'h00);
    // Reload, one-shot and hold while disabled
    wr(6'h04, 8'h03);
    wr(6'h00, 8'h02);
    tick(3, 1'b0);
    rd(6'h00, 8'h02);
    wr(6'h04, 8'h05);
    wr(6'h00, 8'h02);
    tick(5, 1'b0);
    rd(6'h00, 8'h00);
    wr(6'h04, 8'h00);
    wr(6'h00, 8'h09);
    tick(3, 1'b0);
    rd(6'h00, 8'h09);
    $display("test modes done");
    // Pin clocking: instruction ticks ignored, rising then falling edge
    wr(6'h08, 8'h28);
    wr(6'h04, 8'h01);
    tick(2, 1'b0);
    pin_pulse();
    rd(6'h00, 8'h08);
    wr(6'h08, 8'h38);
    pin_pulse();
    rd(6'h00, 8'h07);
    // High oscillator force overrides the pin source; the prescaler stays bypassed meanwhile
    wr(6'h1c, 8'h01);
    tick(2, 1'b1);
    rd(6'h00, 8'h05);
    wr(6'h1c, 8'h00);
    $display("test sources done");
    // Each division: select changed only while bypassed, two periods give two steps
    for (int s = 0; s < 8; s++) begin
      wr(6'h08, 8'h08 | 8'(s));
      wr(6'h00, 8'h80);
      wr(6'h08, 8'(s));
      tick(4 << s, 1'b0);
      rd(6'h00, 8'h7e);
      psc = psc - 8'(4 << s);
      // Bypass first with the old select, so the next select change happens while disabled
      wr(6'h08, 8'h08 | 8'(s));
    end
    wr(6'h08, 8'h0f);
    rd(6'h10, psc);
    // Buzzer prescaler taps against the mirrored count
    for (int k = 0; k < 8; k++) begin
      wr(6'h14, 8'h80 | 8'(k));
      settle();
      check_pin(buzzer_output_o, psc[k]);
    end
    $display("test prescaler done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
